/* acr_params.svh */
// Constants for the configuration register set and result codes
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
// ==========================================
// Clock and time units
`define ACR_CLK_HZ 100000000
`define ACR_MS_PER_S 1000
`define ACR_GUARD_UNIT_MS 1
`define ACR_TIMER_UNIT_S 1
`define ACR_DISC_LEN 2'h3
// ==========================================
// Register numbers
`define ACR_N_ANSWER 8'h00
`define ACR_N_DISC_CHAR 8'h02
`define ACR_N_SETUP 8'h07
`define ACR_N_RECOVERY 8'h0A
`define ACR_N_GUARD 8'h0C
`define ACR_N_FLAGS 8'h0E
`define ACR_N_BAUD 8'h17
`define ACR_N_FLOW 8'h27
`define ACR_N_GROUP 8'h68
`define ACR_N_NODE 8'h69
`define ACR_N_IO 8'h6B
`define ACR_N_TXLEVEL 8'h6C
`define ACR_N_MONITOR 8'h6E
// ==========================================
// Storage slots
`define ACR_S_ANSWER 4'h0
`define ACR_S_DISC_CHAR 4'h1
`define ACR_S_SETUP 4'h2
`define ACR_S_RECOVERY 4'h3
`define ACR_S_GUARD 4'h4
`define ACR_S_FLAGS 4'h5
`define ACR_S_BAUD 4'h6
`define ACR_S_FLOW 4'h7
`define ACR_S_GROUP 4'h8
`define ACR_S_NODE 4'h9
`define ACR_S_IO 4'hA
`define ACR_S_TXLEVEL 4'hB
`define ACR_S_MONITOR 4'hC
`define ACR_S_NONE 4'hF
`define ACR_NSLOT 13
// ==========================================
// Factory defaults
`define ACR_D_ANSWER 8'h00
`define ACR_D_DISC_CHAR 8'h7E
`define ACR_D_SETUP 8'h0A
`define ACR_D_RECOVERY 8'h0A
`define ACR_D_GUARD 8'h14
`define ACR_D_FLAGS 8'h05
`define ACR_D_BAUD 8'h04
`define ACR_D_FLOW 8'h00
`define ACR_D_GROUP 8'h00
`define ACR_D_NODE 8'h01
`define ACR_D_IO 8'hC1
`define ACR_D_TXLEVEL 8'h00
`define ACR_D_MONITOR 8'h02
// ==========================================
// Field values and ranges
`define ACR_ANS_IGNORE 8'h00
`define ACR_ANS_AUTO 8'h01
`define ACR_ANS_BCAST 8'h80
`define ACR_FLOW_NONE 8'h00
`define ACR_FLOW_HW 8'h03
`define ACR_FLOW_SW 8'h04
`define ACR_FLAGS_MAX 8'h07
`define ACR_SEC_MAX 8'h3C
`define ACR_MON_MIN 8'h01
`define ACR_BAUD_MIN 8'h01
`define ACR_BAUD_MAX 8'h0A
`define ACR_NODE_MIN 8'h01
`define ACR_NODE_MAX 8'hFE
`define ACR_F_ECHO 0
`define ACR_F_QUIET 1
`define ACR_F_VERBOSE 2
`define ACR_IO_ANALOG 0
`define ACR_IO_DIR_LO 2
`define ACR_IO_DIR_HI 7
// ==========================================
// Result codes
`define ACR_RC_OK 4'h0
`define ACR_RC_CONNECT 4'h1
`define ACR_RC_RING 4'h2
`define ACR_RC_DISCONNECT 4'h3
`define ACR_RC_ERROR 4'h4
`define ACR_RC_NOCONN 4'h6
`define ACR_RC_BUSY 4'h7
`define ACR_RC_SORRY 4'h8
`define ACR_RC_WAIT 4'h9
`define ACR_NCODE 10
// ==========================================
// Command operations
`define ACR_OP_READ 2'h0
`define ACR_OP_WRITE 2'h1
`define ACR_OP_FACTORY 2'h2
`define ACR_OP_BCAST 2'h3
// ==========================================
// Host baud rates
`define ACR_B1 1200
`define ACR_B2 2400
`define ACR_B3 4800
`define ACR_B4 9600
`define ACR_B5 14400
`define ACR_B6 19200
`define ACR_B7 28800
`define ACR_B8 38400
`define ACR_B9 57600
`define ACR_B10 115200
`endif

/* acr_pkg.sv */
// Types and helper functions of the configuration register set
`include "acr_params.svh"
package acr_pkg;
   typedef enum logic [1:0] {G_QUIET, G_SEQ, G_TAIL} acr_guard_t;
   typedef logic [`ACR_NSLOT-1:0][7:0] acr_regs_t;
   typedef struct packed {
      acr_regs_t regs;
      acr_guard_t gst;
      logic [31:0] ms_div;
      logic [31:0] sec_div;
      logic ms_tick;
      logic sec_tick;
      logic [7:0] guard_cnt;
      logic [1:0] disc_cnt;
      logic setup_on;
      logic [7:0] setup_cnt;
      logic recov_on;
      logic [7:0] recov_cnt;
      logic [7:0] mon_cnt;
      logic [`ACR_NCODE-1:0] pend;
      logic resp_valid;
      logic [3:0] resp_code;
      logic resp_word;
      logic resp_read;
      logic [7:0] resp_data;
      logic answer;
      logic disc_req;
      logic mon_wake;
      logic bcast_on;
      logic tx_valid;
      logic [7:0] tx_byte;
      logic [16:0] baud_div;
      logic [5:0] dir_in;
      logic analog_mode;
      logic bcast_pu;
      logic grp_match;
   } acr_state_t;
   // Factory image of all registers
   function automatic acr_regs_t factory_regs();
      acr_regs_t r;
      r = '0;
      r[`ACR_S_ANSWER] = `ACR_D_ANSWER;
      r[`ACR_S_DISC_CHAR] = `ACR_D_DISC_CHAR;
      r[`ACR_S_SETUP] = `ACR_D_SETUP;
      r[`ACR_S_RECOVERY] = `ACR_D_RECOVERY;
      r[`ACR_S_GUARD] = `ACR_D_GUARD;
      r[`ACR_S_FLAGS] = `ACR_D_FLAGS;
      r[`ACR_S_BAUD] = `ACR_D_BAUD;
      r[`ACR_S_FLOW] = `ACR_D_FLOW;
      r[`ACR_S_GROUP] = `ACR_D_GROUP;
      r[`ACR_S_NODE] = `ACR_D_NODE;
      r[`ACR_S_IO] = `ACR_D_IO;
      r[`ACR_S_TXLEVEL] = `ACR_D_TXLEVEL;
      r[`ACR_S_MONITOR] = `ACR_D_MONITOR;
      return r;
   endfunction
   // Register number to storage slot
   function automatic logic [3:0] slot_of(input logic [7:0] n);
      case (n)
         `ACR_N_ANSWER: slot_of = `ACR_S_ANSWER;
         `ACR_N_DISC_CHAR: slot_of = `ACR_S_DISC_CHAR;
         `ACR_N_SETUP: slot_of = `ACR_S_SETUP;
         `ACR_N_RECOVERY: slot_of = `ACR_S_RECOVERY;
         `ACR_N_GUARD: slot_of = `ACR_S_GUARD;
         `ACR_N_FLAGS: slot_of = `ACR_S_FLAGS;
         `ACR_N_BAUD: slot_of = `ACR_S_BAUD;
         `ACR_N_FLOW: slot_of = `ACR_S_FLOW;
         `ACR_N_GROUP: slot_of = `ACR_S_GROUP;
         `ACR_N_NODE: slot_of = `ACR_S_NODE;
         `ACR_N_IO: slot_of = `ACR_S_IO;
         `ACR_N_TXLEVEL: slot_of = `ACR_S_TXLEVEL;
         `ACR_N_MONITOR: slot_of = `ACR_S_MONITOR;
         default: slot_of = `ACR_S_NONE;
      endcase
   endfunction
endpackage

/* acr_config_core.sv */
// Configuration register set, timers and result-code reporter
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_config_core #(
   parameter int MS_CYCLES = (`ACR_CLK_HZ / `ACR_MS_PER_S) *
                             `ACR_GUARD_UNIT_MS,
   parameter int SEC_CYCLES = `ACR_CLK_HZ * `ACR_TIMER_UNIT_S
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_reg,
   input wire logic [7:0] cmd_data,
   input wire logic rx_char_valid,
   input wire logic [7:0] rx_char,
   input wire logic link_req_in,
   input wire logic link_dial,
   input wire logic link_connected,
   input wire logic link_broken,
   input wire logic link_restored,
   input wire logic link_failed,
   input wire logic link_unavailable,
   input wire logic poll_no_answer,
   input wire logic fault_event,
   input wire logic monitor_mode,
   input wire logic bcast_valid,
   input wire logic [7:0] bcast_byte,
   input wire logic bcast_end,
   input wire logic [7:0] peer_group,
   output logic resp_valid,
   output logic [3:0] resp_code,
   output logic resp_word,
   output logic resp_read,
   output logic [7:0] resp_data,
   output logic answer_link,
   output logic bcast_at_powerup,
   output logic disc_request,
   output logic [7:0] disc_char,
   output logic setup_active,
   output logic recovery_active,
   output logic monitor_wake,
   output logic host_tx_valid,
   output logic [7:0] host_tx_byte,
   output logic [16:0] baud_divisor,
   output logic [7:0] flow_select,
   output logic echo_on,
   output logic [7:0] node_address,
   output logic group_match,
   output logic analog_mode,
   output logic [5:0] line_is_input
);
   import acr_pkg::*;

   // =====================================================
   // Helper functions
   // Value legal for the slot
   function automatic logic in_range(input logic [3:0] s,
                                     input logic [7:0] v);
      case (s)
         `ACR_S_ANSWER: in_range = (v == `ACR_ANS_IGNORE) ||
            (v == `ACR_ANS_AUTO) || (v == `ACR_ANS_BCAST);
         `ACR_S_SETUP, `ACR_S_RECOVERY: in_range = (v <= `ACR_SEC_MAX);
         `ACR_S_FLAGS: in_range = (v <= `ACR_FLAGS_MAX);
         `ACR_S_BAUD: in_range = (v >= `ACR_BAUD_MIN) &&
            (v <= `ACR_BAUD_MAX);
         `ACR_S_FLOW: in_range = (v == `ACR_FLOW_NONE) ||
            (v == `ACR_FLOW_HW) || (v == `ACR_FLOW_SW);
         `ACR_S_NODE: in_range = (v >= `ACR_NODE_MIN) &&
            (v <= `ACR_NODE_MAX);
         `ACR_S_MONITOR: in_range = (v >= `ACR_MON_MIN) &&
            (v <= `ACR_SEC_MAX);
         `ACR_S_NONE: in_range = 1'b0;
         default: in_range = 1'b1;
      endcase
   endfunction

   // Baud selection to clock divisor
   function automatic logic [16:0] baud_div(input logic [7:0] v);
      int b;
      case (v)
         8'h01: b = `ACR_B1;
         8'h02: b = `ACR_B2;
         8'h03: b = `ACR_B3;
         8'h05: b = `ACR_B5;
         8'h06: b = `ACR_B6;
         8'h07: b = `ACR_B7;
         8'h08: b = `ACR_B8;
         8'h09: b = `ACR_B9;
         8'h0A: b = `ACR_B10;
         default: b = `ACR_B4;
      endcase
      return 17'(`ACR_CLK_HZ / b);
   endfunction

   // =====================================================
   // State
   acr_state_t q, d;
   logic [3:0] cslot;
   logic [7:0] v_io;
   logic [`ACR_NCODE-1:0] ev;
   logic [`ACR_NCODE-1:0] ev_clr;
   logic cmd_done;

   // =====================================================
   // Next-state logic
   always_comb begin
      d = q;
      cmd_done = 1'b0;
      ev = '0;
      ev_clr = '0;
      cslot = slot_of(cmd_reg);
      d.ms_tick = 1'b0;
      d.sec_tick = 1'b0;
      d.answer = 1'b0;
      d.disc_req = 1'b0;
      d.mon_wake = 1'b0;
      d.resp_valid = 1'b0;
      d.resp_read = 1'b0;
      d.tx_valid = 1'b0;

      // Millisecond and second tick dividers
      if (q.ms_div >= 32'(MS_CYCLES - 1)) begin
         d.ms_div = '0;
         d.ms_tick = 1'b1;
      end else begin
         d.ms_div = q.ms_div + 32'h1;
      end
      if (q.sec_div >= 32'(SEC_CYCLES - 1)) begin
         d.sec_div = '0;
         d.sec_tick = 1'b1;
      end else begin
         d.sec_div = q.sec_div + 32'h1;
      end

      // Register commands from the host
      if (cmd_valid) begin
         cmd_done = 1'b1;
         d.resp_valid = 1'b1;
         d.resp_word = q.regs[`ACR_S_FLAGS][`ACR_F_VERBOSE];
         d.resp_data = 8'h00;
         d.resp_code = `ACR_RC_OK;
         case (cmd_op)
            `ACR_OP_READ: begin
               if (cslot == `ACR_S_NONE) begin
                  d.resp_code = `ACR_RC_ERROR;
               end else begin
                  d.resp_read = 1'b1;
                  d.resp_data = q.regs[cslot];
               end
            end
            `ACR_OP_WRITE: begin
               if (in_range(cslot, cmd_data)) begin
                  d.regs[cslot] = cmd_data;
               end else begin
                  d.resp_code = `ACR_RC_ERROR;
               end
            end
            `ACR_OP_FACTORY: begin
               d.regs = factory_regs();
            end
            default: begin
               d.bcast_on = 1'b1;
            end
         endcase
         // Quiet flag hides result codes, not read data
         if (q.regs[`ACR_S_FLAGS][`ACR_F_QUIET] && !d.resp_read) begin
            d.resp_valid = 1'b0;
         end
      end

      // Broadcast forwarding to the host serial side
      if (q.bcast_on && bcast_valid) begin
         d.tx_valid = 1'b1;
         d.tx_byte = bcast_byte;
      end
      if (q.bcast_on && bcast_end) begin
         d.bcast_on = 1'b0;
      end

      // Incoming link request handling
      if (link_req_in) begin
         ev[`ACR_RC_RING] = 1'b1;
         d.answer = (q.regs[`ACR_S_ANSWER] == `ACR_ANS_AUTO);
      end

      // Link set-up timer
      if (link_dial) begin
         d.setup_on = 1'b1;
         d.setup_cnt = q.regs[`ACR_S_SETUP];
      end else if (q.setup_on && link_connected) begin
         d.setup_on = 1'b0;
      end else if (q.setup_on && q.setup_cnt == 8'h00) begin
         d.setup_on = 1'b0;
         ev[`ACR_RC_BUSY] = 1'b1;
      end else if (q.setup_on && q.sec_tick) begin
         d.setup_cnt = q.setup_cnt - 8'h01;
      end

      // Link recovery timer
      if (link_broken) begin
         d.recov_on = 1'b1;
         d.recov_cnt = q.regs[`ACR_S_RECOVERY];
      end else if (q.recov_on && link_restored) begin
         d.recov_on = 1'b0;
      end else if (q.recov_on && q.recov_cnt == 8'h00) begin
         d.recov_on = 1'b0;
         ev[`ACR_RC_DISCONNECT] = 1'b1;
      end else if (q.recov_on && q.sec_tick) begin
         d.recov_cnt = q.recov_cnt - 8'h01;
      end

      // Monitor wake interval
      if (!monitor_mode) begin
         d.mon_cnt = 8'h00;
      end else if (q.sec_tick) begin
         if (q.mon_cnt + 8'h01 >= q.regs[`ACR_S_MONITOR]) begin
            d.mon_cnt = 8'h00;
            d.mon_wake = 1'b1;
         end else begin
            d.mon_cnt = q.mon_cnt + 8'h01;
         end
      end

      // Disconnect sequence with guard periods
      case (q.gst)
         G_QUIET: begin
            if (rx_char_valid) begin
               d.guard_cnt = 8'h00;
            end else if (q.guard_cnt >= q.regs[`ACR_S_GUARD]) begin
               d.gst = G_SEQ;
               d.disc_cnt = 2'h0;
            end else if (q.ms_tick) begin
               d.guard_cnt = q.guard_cnt + 8'h01;
            end
         end
         G_SEQ: begin
            if (rx_char_valid) begin
               d.guard_cnt = 8'h00;
               if (rx_char == q.regs[`ACR_S_DISC_CHAR]) begin
                  d.disc_cnt = q.disc_cnt + 2'h1;
                  if (q.disc_cnt + 2'h1 == `ACR_DISC_LEN) begin
                     d.gst = G_TAIL;
                  end
               end else begin
                  d.gst = G_QUIET;
               end
            end
         end
         G_TAIL: begin
            if (rx_char_valid) begin
               d.gst = G_QUIET;
               d.guard_cnt = 8'h00;
            end else if (q.guard_cnt >= q.regs[`ACR_S_GUARD]) begin
               d.disc_req = 1'b1;
               d.gst = G_QUIET;
               d.guard_cnt = 8'h00;
            end else if (q.ms_tick) begin
               d.guard_cnt = q.guard_cnt + 8'h01;
            end
         end
         default: begin
            d.gst = G_QUIET;
         end
      endcase

      // Other link events
      ev[`ACR_RC_CONNECT] = link_connected;
      ev[`ACR_RC_ERROR] = fault_event;
      ev[`ACR_RC_NOCONN] = link_failed;
      ev[`ACR_RC_SORRY] = poll_no_answer;
      ev[`ACR_RC_WAIT] = link_unavailable;

      // Pending event report, lowest code first, after commands
      if (!cmd_done) begin
         for (int i = 0; i < `ACR_NCODE; i++) begin
            if (q.pend[i] && ev_clr == '0) begin
               ev_clr[i] = 1'b1;
               d.resp_code = 4'(i);
               d.resp_word = q.regs[`ACR_S_FLAGS][`ACR_F_VERBOSE];
               d.resp_data = 8'h00;
               d.resp_valid = !q.regs[`ACR_S_FLAGS][`ACR_F_QUIET];
            end
         end
      end
      // New events win over the clear of the same flag
      d.pend = (q.pend & ~ev_clr) | ev;

      // Derived configuration outputs
      v_io = d.regs[`ACR_S_IO];
      d.baud_div = baud_div(d.regs[`ACR_S_BAUD]);
      d.analog_mode = v_io[`ACR_IO_ANALOG];
      d.dir_in[3:0] = v_io[`ACR_IO_DIR_LO+3:`ACR_IO_DIR_LO];
      // Lines 4 and 5 forced to input while pins are analog
      d.dir_in[5:4] = v_io[`ACR_IO_DIR_HI:`ACR_IO_DIR_HI-1] |
                      {2{v_io[`ACR_IO_ANALOG]}};
      // Registered copies of the register compares
      d.bcast_pu = (d.regs[`ACR_S_ANSWER] == `ACR_ANS_BCAST);
      d.grp_match = (peer_group == d.regs[`ACR_S_GROUP]);
   end

   // =====================================================
   // State register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.regs <= factory_regs();
         q.gst <= G_QUIET;
         q.baud_div <= 17'(`ACR_CLK_HZ / `ACR_B4);
         q.dir_in <= 6'h30;
         q.analog_mode <= 1'b1;
         q.resp_word <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // =====================================================
   // Outputs, all from the state register
   assign resp_valid = q.resp_valid;
   assign resp_code = q.resp_code;
   assign resp_word = q.resp_word;
   assign resp_read = q.resp_read;
   assign resp_data = q.resp_data;
   assign answer_link = q.answer;
   // Follows the stored answer value on the same clock edge that writes it
   assign bcast_at_powerup = q.bcast_pu;
   assign disc_request = q.disc_req;
   assign disc_char = q.regs[`ACR_S_DISC_CHAR];
   assign setup_active = q.setup_on;
   assign recovery_active = q.recov_on;
   assign monitor_wake = q.mon_wake;
   assign host_tx_valid = q.tx_valid;
   assign host_tx_byte = q.tx_byte;
   assign baud_divisor = q.baud_div;
   assign flow_select = q.regs[`ACR_S_FLOW];
   assign echo_on = q.regs[`ACR_S_FLAGS][`ACR_F_ECHO];
   assign node_address = q.regs[`ACR_S_NODE];
   assign group_match = q.grp_match;
   assign analog_mode = q.analog_mode;
   assign line_is_input = q.dir_in;
endmodule

/* acr_config_core_assertions.sv */
// Port checker for the configuration register set
`timescale 1ns/1ps
`include "acr_params.svh"
module acr_config_core_assertions #(
   parameter int MS_CYCLES = 100000,
   parameter int SEC_CYCLES = 100000000
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_op,
   input wire logic [7:0] cmd_reg,
   input wire logic [7:0] cmd_data,
   input wire logic rx_char_valid,
   input wire logic link_req_in,
   input wire logic monitor_mode,
   input wire logic resp_valid,
   input wire logic resp_read,
   input wire logic answer_link,
   input wire logic disc_request,
   input wire logic monitor_wake,
   input wire logic [16:0] baud_divisor,
   input wire logic [7:0] node_address,
   input wire logic analog_mode,
   input wire logic [5:0] line_is_input
);
   logic [7:0] quiet_q;
   // ====
   // Cycles since the last host character
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         quiet_q <= 8'h00;
      end else if (rx_char_valid) begin
         quiet_q <= 8'h00;
      end else if (quiet_q != 8'hFF) begin
         quiet_q <= quiet_q + 8'h01;
      end
   end
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);
   // Command shapes
   sequence s_read;
      cmd_valid && cmd_op == `ACR_OP_READ && cmd_reg == `ACR_N_SETUP;
   endsequence
   sequence s_bad_baud;
      cmd_valid && cmd_op == `ACR_OP_WRITE && cmd_reg == `ACR_N_BAUD &&
         (cmd_data == 8'h00 || cmd_data > `ACR_BAUD_MAX);
   endsequence
   a_read_answered: assert property (s_read |=>
      resp_valid && resp_read) else $error("read not answered next cycle");
   a_read_source: assert property (resp_read |->
      $past(cmd_valid) && $past(cmd_op) == `ACR_OP_READ)
      else $error("read data without a read");
   a_bad_baud_kept: assert property (s_bad_baud |=>
      $stable(baud_divisor)) else $error("rejected rate changed divisor");
   a_baud_cause: assert property (!$stable(baud_divisor) |->
      $past(cmd_valid)) else $error("divisor moved without command");
   a_node_cause: assert property (!$stable(node_address) |->
      $past(cmd_valid)) else $error("node address moved without command");
   a_analog_input: assert property (analog_mode |->
      line_is_input[5:4] == 2'h3) else $error("analog pins not inputs");
   a_answer_cause: assert property (answer_link |->
      $past(link_req_in)) else $error("answer without link request");
   a_wake_mode: assert property (monitor_wake |->
      $past(monitor_mode)) else $error("wake outside monitor mode");
   a_disc_quiet: assert property (disc_request |-> quiet_q >= 8'h08)
      else $error("disconnect without quiet tail");
endmodule

bind acr_config_core acr_config_core_assertions #(.MS_CYCLES(MS_CYCLES),
   .SEC_CYCLES(SEC_CYCLES)) u_chk (.sys_clk(sys_clk), .resetn(resetn),
   .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_reg(cmd_reg),
   .cmd_data(cmd_data), .rx_char_valid(rx_char_valid),
   .link_req_in(link_req_in), .monitor_mode(monitor_mode),
   .resp_valid(resp_valid), .resp_read(resp_read),
   .answer_link(answer_link), .disc_request(disc_request),
   .monitor_wake(monitor_wake), .baud_divisor(baud_divisor),
   .node_address(node_address), .analog_mode(analog_mode),
   .line_is_input(line_is_input));

/* acr_host_model.sv */
// Host model issuing register commands and serial characters
`timescale 1ns/1ps
module acr_host_model (
   input wire logic sys_clk,
   output logic cmd_valid,
   output logic [1:0] cmd_op,
   output logic [7:0] cmd_reg,
   output logic [7:0] cmd_data,
   output logic rx_char_valid,
   output logic [7:0] rx_char,
   input wire logic resp_valid,
   input wire logic [3:0] resp_code,
   input wire logic [7:0] resp_data
);
   logic [3:0] got_code;
   logic [7:0] got_data;
   // ====
   // Idle levels
   initial begin
      cmd_valid = 1'b0;
      cmd_op = 2'h0;
      cmd_reg = 8'h00;
      cmd_data = 8'h00;
      rx_char_valid = 1'b0;
      rx_char = 8'h00;
   end
   // Set or query one register, capture the answer
   task automatic cmd(input logic [1:0] op, input logic [7:0] rn,
      input logic [7:0] d);
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_reg = rn;
      cmd_data = d;
      @(negedge sys_clk);
      got_code = resp_code;
      got_data = resp_data;
      cmd_valid = 1'b0;
      cmd_data = ~d; // Released bus shows no stale value
   endtask
   // One serial character
   task automatic ch(input logic [7:0] c);
      @(negedge sys_clk);
      rx_char_valid = 1'b1;
      rx_char = c;
      @(negedge sys_clk);
      rx_char_valid = 1'b0;
      rx_char = ~c;
   endtask
endmodule

/* at_config_register_set_tb.sv */
// Self-checking bench of the configuration register set
`timescale 1ns/1ps
module at_config_register_set_tb;
   logic sys_clk, resetn, cmd_valid, rx_char_valid, mon, seen;
   logic [1:0] cmd_op;
   logic [7:0] cmd_reg, cmd_data, rx_char, bb, pg, host_tx_byte, disc_char;
   logic [7:0] resp_data, flow_select, node_address;
   logic [10:0] ev;
   logic resp_valid, resp_word, resp_read, answer_link, bcast_at_powerup;
   logic disc_request, setup_active, recovery_active, monitor_wake;
   logic host_tx_valid, echo_on, group_match, analog_mode;
   logic [3:0] resp_code;
   logic [16:0] baud_divisor;
   logic [5:0] line_is_input;
   int n_errors, checks_done, cyc, k;
   // ====
   acr_config_core #(.MS_CYCLES(10), .SEC_CYCLES(50)) dut (
      .sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .link_req_in(ev[0]), .link_dial(ev[1]), .link_connected(ev[2]),
      .link_broken(ev[3]), .link_restored(ev[4]), .link_failed(ev[5]),
      .link_unavailable(ev[6]), .poll_no_answer(ev[7]),
      .fault_event(ev[8]), .monitor_mode(mon), .bcast_valid(ev[9]),
      .bcast_byte(bb), .bcast_end(ev[10]), .peer_group(pg),
      .resp_valid(resp_valid), .resp_code(resp_code),
      .resp_word(resp_word), .resp_read(resp_read),
      .resp_data(resp_data), .answer_link(answer_link),
      .bcast_at_powerup(bcast_at_powerup), .disc_request(disc_request),
      .disc_char(disc_char), .setup_active(setup_active),
      .recovery_active(recovery_active), .monitor_wake(monitor_wake),
      .host_tx_valid(host_tx_valid), .host_tx_byte(host_tx_byte),
      .baud_divisor(baud_divisor), .flow_select(flow_select),
      .echo_on(echo_on), .node_address(node_address),
      .group_match(group_match), .analog_mode(analog_mode),
      .line_is_input(line_is_input));
   acr_host_model host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_reg(cmd_reg), .cmd_data(cmd_data),
      .rx_char_valid(rx_char_valid), .rx_char(rx_char),
      .resp_valid(resp_valid), .resp_code(resp_code),
      .resp_data(resp_data));
   // Clock and hang guard
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic pulse(input int i);
      @(negedge sys_clk);
      ev[i] = 1'b1;
      @(negedge sys_clk);
      ev[i] = 1'b0;
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return resp_valid;
         1: return monitor_wake;
         2: return host_tx_valid;
         default: return disc_request;
      endcase
   endfunction
   task automatic wait_hi(input int s, input int n);
      k = 0;
      while (pick(s) !== 1'b1 && k < n) begin
         @(negedge sys_clk);
         k++;
      end
   endtask
   task automatic t_defaults;
      logic [15:0] d [13] = '{16'h0000, 16'h027E, 16'h070A, 16'h0A0A,
         16'h0C14, 16'h0E05, 16'h1704, 16'h2700, 16'h6800, 16'h6901,
         16'h6BC1, 16'h6C00, 16'h6E02};
      for (int i = 0; i < 13; i++) begin
         host.cmd(2'h0, d[i][15:8], 8'h00);
         chk({resp_read, host.got_data}, {1'b1, d[i][7:0]});
      end
      chk({disc_char, baud_divisor}, {8'h7E, 17'h28B0});
      host.cmd(2'h0, 8'h01, 8'h00);
      chk({resp_read, host.got_code}, 5'h04);
   endtask
   task automatic t_writes;
      int r [10] = '{1200, 2400, 4800, 9600, 14400, 19200, 28800, 38400,
         57600, 115200};
      for (int i = 0; i < 10; i++) begin
         host.cmd(2'h1, 8'h17, 8'(i + 1));
         chk(baud_divisor, 32'h05F5E100 / r[i]);
      end
      host.cmd(2'h1, 8'h17, 8'h00);
      chk({host.got_code, baud_divisor}, {4'h4, 17'h364});
      host.cmd(2'h1, 8'h27, 8'h03);
      host.cmd(2'h1, 8'h27, 8'h02);
      chk({host.got_code, flow_select}, 12'h403);
      host.cmd(2'h1, 8'h69, 8'hFE); // Unique address per unit
      chk(node_address, 8'hFE);
      host.cmd(2'h2, 8'h00, 8'h00);
      chk({baud_divisor, node_address}, {17'h28B0, 8'h01});
   endtask
   task automatic t_io;
      host.cmd(2'h1, 8'h6B, 8'h3C);
      chk({analog_mode, line_is_input}, 7'h0F);
      host.cmd(2'h1, 8'h6B, 8'h81);
      chk({analog_mode, line_is_input}, 7'h70);
      host.cmd(2'h1, 8'h6B, 8'h40);
      chk({analog_mode, line_is_input}, 7'h10);
   endtask
   task automatic t_events;
      logic [7:0] e [6] = '{8'h78, 8'h56, 8'h69, 8'h84, 8'h21, 8'h02};
      for (int i = 0; i < 6; i++) begin
         pulse(e[i][7:4]);
         wait_hi(0, 8);
         chk({resp_word, resp_code}, {1'b1, e[i][3:0]});
      end
      host.cmd(2'h1, 8'h0E, 8'h00);
      pulse(7);
      wait_hi(0, 8);
      chk({echo_on, resp_word, resp_code}, 6'h08);
      host.cmd(2'h1, 8'h0E, 8'h07);
      pulse(8);
      wait_hi(0, 8);
      chk(resp_valid, 1'b0);
      host.cmd(2'h1, 8'h0E, 8'h05);
   endtask
   task automatic t_timers;
      host.cmd(2'h1, 8'h07, 8'h01);
      pulse(1);
      chk(setup_active, 1'b1);
      wait_hi(0, 150);
      chk({resp_word, resp_code, setup_active}, 6'h2E);
      host.cmd(2'h1, 8'h0A, 8'h01);
      pulse(3);
      chk(recovery_active, 1'b1);
      wait_hi(0, 150);
      chk({resp_word, resp_code}, 5'h13);
   endtask
   task automatic t_answer;
      host.cmd(2'h1, 8'h00, 8'h01);
      pulse(0);
      seen = answer_link;
      wait_hi(0, 8);
      chk({seen, resp_code}, 5'h12);
      host.cmd(2'h1, 8'h00, 8'h80); // Host writes the broadcast answer value
      chk(bcast_at_powerup, 1'b1);
      host.cmd(2'h1, 8'h00, 8'h02);
      chk({host.got_code, bcast_at_powerup}, 5'h09);
   endtask
   task automatic t_disc;
      host.cmd(2'h1, 8'h0C, 8'h02);
      repeat (30) @(negedge sys_clk);
      repeat (3) host.ch(8'h7E);
      wait_hi(3, 40);
      chk(disc_request, 1'b1);
      host.cmd(2'h1, 8'h02, 8'h2B);
      repeat (30) @(negedge sys_clk);
      repeat (3) host.ch(8'h2B);
      repeat (5) @(negedge sys_clk);
      host.ch(8'h41);
      wait_hi(3, 40);
      chk(disc_request, 1'b0);
   endtask
   task automatic t_misc;
      host.cmd(2'h1, 8'h68, 8'h05);
      pg = 8'h05;
      @(negedge sys_clk);
      chk(group_match, 1'b1);
      pg = 8'h06;
      @(negedge sys_clk);
      chk(group_match, 1'b0);
      host.cmd(2'h3, 8'h00, 8'h00);
      bb = 8'hA5;
      pulse(9);
      wait_hi(2, 6);
      chk({host_tx_valid, host_tx_byte}, 9'h1A5);
      pulse(10);
      mon = 1'b1;
      wait_hi(1, 300);
      @(negedge sys_clk);
      wait_hi(1, 300);
      chk(k + 1, 100);
   endtask
   // Main sequence
   initial begin
      sys_clk = 1'b0;
      resetn = 1'b0;
      ev = '0;
      mon = 1'b0;
      bb = 8'h00;
      pg = 8'h00;
      repeat (4) @(negedge sys_clk);
      resetn = 1'b1;
      t_defaults;
      t_writes;
      t_io;
      t_events;
      t_timers;
      t_answer;
      t_disc;
      t_misc;
      tally_and_finish;
   end
endmodule
